// file: design/mies_exec.sv
`timescale 1ns/10ps
module mies_exec
   import mies_pkg::*;
#(
   parameter int unsigned SP_W = 3  // stack level width
)
(
   // clock and reset
   input logic sys_clk_i,
   input logic rst_b_i,
   // decoded instruction
   input logic instr_valid_i,
   input mies_pkg::mies_op_e op_i,
   input logic dest_bit_i,
   input logic [mies_pkg::RADDR_W-1:0] reg_addr_i,
   input logic [mies_pkg::DATA_W-1:0] imm_i,
   input logic [mies_pkg::SADDR_W-1:0] sfr_addr_i,
   input logic [mies_pkg::PC_W-1:0] call_target_i,
   input logic [mies_pkg::PC_W-1:0] pc_i,
   // read data for the addressed operands
   input logic [mies_pkg::DATA_W-1:0] reg_rdata_i,
   input logic [mies_pkg::DATA_W-1:0] sfr_rdata_i,
   // fetch control
   output logic busy_o,
   output logic flush_o,
   // accumulator and status
   output logic [mies_pkg::DATA_W-1:0] acc_o,
   output logic zero_o,
   // data register write
   output logic reg_we_o,
   output logic [mies_pkg::RADDR_W-1:0] reg_waddr_o,
   output logic [mies_pkg::DATA_W-1:0] reg_wdata_o,
   // alternate page write
   output logic sfr_we_o,
   output logic [mies_pkg::SADDR_W-1:0] sfr_waddr_o,
   output logic [mies_pkg::DATA_W-1:0] sfr_wdata_o,
   // return stack push
   output logic push_o,
   output logic [SP_W-1:0] push_level_o,
   output logic [mies_pkg::PC_W-1:0] push_data_o,
   output logic [SP_W-1:0] sp_o,
   // program counter load
   output logic pc_load_o,
   output logic [mies_pkg::PC_W-1:0] pc_target_o
);

   // ==========================================================
   // state
   mies_state_e state_q, state_d;
   logic [DATA_W-1:0] acc_q, acc_d;    // accumulator
   logic zero_q, zero_d;               // zero flag
   logic [SP_W-1:0] sp_q, sp_d;        // next free stack level
   logic busy_q, flush_q, reg_we_q, sfr_we_q, push_q, pc_load_q;
   logic [RADDR_W-1:0] reg_waddr_q;
   logic [DATA_W-1:0] reg_wdata_q;
   logic [SADDR_W-1:0] sfr_waddr_q;
   logic [DATA_W-1:0] sfr_wdata_q;
   logic [SP_W-1:0] push_level_q;
   logic [PC_W-1:0] push_data_q;
   logic [PC_W-1:0] target_q;          // held across the two call cycles

   // ==========================================================
   // decode, only taken while idle so a second cycle never overlaps
   wire take = instr_valid_i & (state_q == ST_IDLE);
   wire do_inc = take & (op_i == OP_INC_SKIP_IF_ZERO);
   wire do_orr = take & (op_i == OP_OR_ACC_WITH_REG);
   wire do_ori = take & (op_i == OP_OR_IMM_WITH_ACC);
   wire do_rds = take & (op_i == OP_READ_SPECIAL_PAGE_REG);
   wire do_wrs = take & (op_i == OP_WRITE_SPECIAL_PAGE_REG);
   wire do_call = take & (op_i == OP_LONG_SUBROUTINE_CALL);
   // indices below the readable range are ignored, accumulator holds
   wire rds_ok = do_rds & (sfr_addr_i >= SFR_RD_MIN);
   wire to_acc = dest_bit_i == DEST_ACC;

   // ==========================================================
   // shared increment and or unit
   logic [DATA_W-1:0] alu_res;
   logic alu_zero;
   mies_alu u_alu (
      .op_i(op_i),
      .acc_i(acc_q),
      .reg_i(reg_rdata_i),
      .imm_i(imm_i),
      .res_o(alu_res),
      .zero_o(alu_zero)
   );

   // ==========================================================
   // next values
   wire alu_to_acc = ((do_inc | do_orr) & to_acc) | do_ori;
   wire alu_to_reg = (do_inc | do_orr) & ~to_acc;
   wire skip = do_inc & alu_zero;
   // the increment leaves the zero flag alone, only the two ors touch it
   assign zero_d = (do_orr | do_ori) ? alu_zero : zero_q;
   assign acc_d = alu_to_acc ? alu_res :
                  rds_ok ? sfr_rdata_i : acc_q;
   assign sp_d = do_call ? sp_q + SP_W'(1) : sp_q;
   assign state_d = skip ? ST_SKIP_NOP :
                    do_call ? ST_CALL_JUMP : ST_IDLE;

   // ==========================================================
   // sequencer, accumulator, flag and stack level
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         acc_q <= ACC_RST;
         zero_q <= ZERO_RST;
         sp_q <= SP_W'(SP_RST);
      end else begin
         state_q <= state_d;
         acc_q <= acc_d;
         zero_q <= zero_d;
         sp_q <= sp_d;
      end
   end

   // ==========================================================
   // one-cycle strobes toward fetch, registers, stack and pc
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         busy_q <= 1'b0;
         flush_q <= 1'b0;
         reg_we_q <= 1'b0;
         sfr_we_q <= 1'b0;
         push_q <= 1'b0;
         pc_load_q <= 1'b0;
      end else begin
         busy_q <= skip | do_call;
         flush_q <= skip;
         reg_we_q <= alu_to_reg;
         sfr_we_q <= do_wrs;
         push_q <= do_call;
         pc_load_q <= state_q == ST_CALL_JUMP;
      end
   end

   // ==========================================================
   // payloads, captured on every take, the call target one cycle ahead of its pc load strobe
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         reg_waddr_q <= '0;
         reg_wdata_q <= '0;
         sfr_waddr_q <= '0;
         sfr_wdata_q <= '0;
         push_level_q <= '0;
         push_data_q <= '0;
         target_q <= '0;
      end else if (take) begin
         reg_waddr_q <= reg_addr_i;
         reg_wdata_q <= alu_res;
         sfr_waddr_q <= sfr_addr_i;
         sfr_wdata_q <= acc_q;
         push_level_q <= sp_q;
         push_data_q <= pc_i + ONE_PC;
         target_q <= call_target_i;
      end
   end

   // ==========================================================
   // outputs, all straight from flops
   assign busy_o = busy_q;
   assign flush_o = flush_q;
   assign acc_o = acc_q;
   assign zero_o = zero_q;
   assign reg_we_o = reg_we_q;
   assign reg_waddr_o = reg_waddr_q;
   assign reg_wdata_o = reg_wdata_q;
   assign sfr_we_o = sfr_we_q;
   assign sfr_waddr_o = sfr_waddr_q;
   assign sfr_wdata_o = sfr_wdata_q;
   assign push_o = push_q;
   assign push_level_o = push_level_q;
   assign push_data_o = push_data_q;
   assign sp_o = sp_q;
   assign pc_load_o = pc_load_q;
   assign pc_target_o = target_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_inc_dest_value: assert property (
      do_inc & to_acc |=> acc_o == $past(reg_rdata_i) + ONE_DATA && !reg_we_o)
      else $error("increment to acc wrong");
   a_inc_reg_value: assert property (
      do_inc & ~to_acc |=> reg_we_o && reg_wdata_o == $past(reg_rdata_i) + ONE_DATA
         && reg_waddr_o == $past(reg_addr_i))
      else $error("increment to register wrong");
   a_skip_two_cycles: assert property (
      do_inc && reg_rdata_i == 8'hFF |=> flush_o && busy_o ##1 !busy_o && !flush_o)
      else $error("skip did not last two cycles");
   a_orr_result: assert property (
      do_orr |=> !busy_o && zero_o == ($past(acc_q | reg_rdata_i) == '0))
      else $error("register or flag wrong");
   a_ori_result: assert property (
      do_ori |=> !busy_o && acc_o == ($past(acc_q) | $past(imm_i)))
      else $error("immediate or wrong");
   a_rds_move: assert property (
      rds_ok |=> acc_o == $past(sfr_rdata_i) && $stable(zero_o) && !busy_o)
      else $error("alt page read wrong");
   a_wrs_move: assert property (
      do_wrs |=> sfr_we_o && sfr_wdata_o == $past(acc_q) && $stable(zero_o))
      else $error("alt page write wrong");
   a_call_push: assert property (
      do_call |=> push_o && push_data_o == $past(pc_i) + ONE_PC
         && push_level_o == $past(sp_q))
      else $error("call push wrong");
   a_call_jump: assert property (
      do_call |=> busy_o && !pc_load_o ##1 pc_load_o && !busy_o
         && pc_target_o == $past(call_target_i, 2))
      else $error("call jump wrong");
   a_sp_advance: assert property (
      do_call |=> sp_o == $past(sp_q) + SP_W'(1))
      else $error("stack level did not advance");

   c_skip: cover property (do_inc ##1 flush_o);
   c_call: cover property (do_call ##2 pc_load_o);
   c_ori_zero: cover property (do_ori && alu_zero);
   c_wrs: cover property (do_wrs);

endmodule

// file: inc/mies_pkg.sv
// ==========================================================
// shared constants and types for the instruction subset executor
package mies_pkg;

   // ==========================================================
   // widths of the datapath
   localparam int unsigned DATA_W = 8;      // accumulator and register width
   localparam int unsigned RADDR_W = 6;     // data register index, 0 to 63
   localparam int unsigned SADDR_W = 4;     // alternate page index, 0 to 15
   localparam int unsigned PC_W = 10;       // program counter, 0 to 1023

   // ==========================================================
   // field values and reset values
   localparam logic [SADDR_W-1:0] SFR_RD_MIN = 4'h5;  // lowest readable alt page index
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;     // accumulator after reset
   localparam logic ZERO_RST = 1'b0;                  // zero flag after reset
   localparam int unsigned SP_RST = 0;                // stack level after reset
   localparam logic [DATA_W-1:0] ONE_DATA = 8'h01;    // increment step
   localparam logic [PC_W-1:0] ONE_PC = 10'h001;      // return address step
   localparam logic DEST_ACC = 1'b0;                  // destination bit: accumulator

   // ==========================================================
   // instruction selector from the decode stage
   typedef enum logic [2:0] {
      OP_NOP = 3'b000,
      OP_INC_SKIP_IF_ZERO = 3'b001,
      OP_OR_ACC_WITH_REG = 3'b010,
      OP_OR_IMM_WITH_ACC = 3'b011,
      OP_READ_SPECIAL_PAGE_REG = 3'b100,
      OP_WRITE_SPECIAL_PAGE_REG = 3'b101,
      OP_LONG_SUBROUTINE_CALL = 3'b110
   } mies_op_e;

   // ==========================================================
   // executor sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,      // ready for a new instruction
      ST_SKIP_NOP = 2'b01,  // second cycle, fetched word discarded
      ST_CALL_JUMP = 2'b10  // second cycle of a call, return address pushed, program counter load strobe follows
   } mies_state_e;

endpackage

// file: design/mies_alu.sv
`timescale 1ns/10ps
// ==========================================================
// increment and or unit, purely combinational
module mies_alu
   import mies_pkg::*;
(
   // operation select
   input logic [2:0] op_i,
   // operands
   input logic [mies_pkg::DATA_W-1:0] acc_i,
   input logic [mies_pkg::DATA_W-1:0] reg_i,
   input logic [mies_pkg::DATA_W-1:0] imm_i,
   // result
   output logic [mies_pkg::DATA_W-1:0] res_o,
   output logic zero_o
);

   // ==========================================================
   // operand selection
   wire [DATA_W-1:0] inc_res = reg_i + ONE_DATA;  // wraps 0xff to 0x00
   wire [DATA_W-1:0] orr_res = acc_i | reg_i;
   wire [DATA_W-1:0] ori_res = acc_i | imm_i;

   // select by operation, the caller ignores other codes
   assign res_o = (op_i == OP_INC_SKIP_IF_ZERO) ? inc_res :
                  (op_i == OP_OR_ACC_WITH_REG) ? orr_res : ori_res;
   assign zero_o = (res_o == '0);

endmodule

// file: testbench/mies_exec_test.sv
`timescale 1ns/10ps
// ==========================================
// random and corner-case bench for the instruction subset executor
module mies_exec_test;
   import mies_pkg::*;
   localparam int unsigned SP_W = 3; // eight stack levels, wraps
   // ==========================================
   // design inputs and outputs
   logic clk, rst_b, vld, dst, busy, flush, zero, rwe, swe, push, pld;
   mies_op_e op;
   logic [5:0] ra, rwa;
   logic [7:0] imm, rrd, srd, acc, wd, sd;
   logic [3:0] sa, swa;
   logic [9:0] tgt, pc, pd, pt;
   logic [2:0] pl, sp;
   // ==========================================
   // reference state kept by the bench
   logic [7:0] m_acc;
   logic m_z;
   logic [2:0] m_sp;
   logic [31:0] seed = 32'h0000_003D; // fixed seed keeps runs repeatable
   int err_count = 0;
   int n_tests = 0;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

   mies_exec #(.SP_W(SP_W)) u_mies_exec (.sys_clk_i(clk), .rst_b_i(rst_b),
      .instr_valid_i(vld), .op_i(op), .dest_bit_i(dst), .reg_addr_i(ra), .imm_i(imm),
      .sfr_addr_i(sa), .call_target_i(tgt), .pc_i(pc), .reg_rdata_i(rrd),
      .sfr_rdata_i(srd), .busy_o(busy), .flush_o(flush), .acc_o(acc), .zero_o(zero),
      .reg_we_o(rwe), .reg_waddr_o(rwa), .reg_wdata_o(wd), .sfr_we_o(swe),
      .sfr_waddr_o(swa), .sfr_wdata_o(sd), .push_o(push), .push_level_o(pl),
      .push_data_o(pd), .sp_o(sp), .pc_load_o(pld), .pc_target_o(pt));

   // clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // xorshift generator
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected result of the increment and the two ors, worked out from the rules
   function automatic logic [7:0] exp_alu(mies_op_e o, logic [7:0] a, logic [7:0] r,
                                          logic [7:0] i);
      case (o)
         OP_INC_SKIP_IF_ZERO: return r + ONE_DATA;
         OP_OR_ACC_WITH_REG: return a | r;
         default: return a | i;
      endcase
   endfunction

   // prints counts and verdict, ends the run
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one instruction; rf keeps valid up during the busy cycle to try a refused take
   task automatic run(mies_op_e o, logic d, logic [5:0] a, logic [7:0] i, logic [7:0] r,
                      logic [7:0] s, logic [3:0] f, logic [9:0] t, logic [9:0] p, logic rf);
      logic [7:0] res;
      logic [7:0] old;
      logic [2:0] osp;
      logic two;
      logic ew;
      @(posedge clk);
      op <= o; dst <= d; ra <= a; imm <= i; rrd <= r; srd <= s; sa <= f; tgt <= t;
      pc <= p; vld <= 1'b1;
      old = m_acc; osp = m_sp; res = 8'h00; two = 1'b0;
      case (o)
         OP_INC_SKIP_IF_ZERO: begin
            res = exp_alu(o, m_acc, r, i);
            two = (res == 8'h00);
            if (!d) m_acc = res;
         end
         OP_OR_ACC_WITH_REG: begin
            res = exp_alu(o, m_acc, r, i);
            m_z = (res == 8'h00);
            if (!d) m_acc = res;
         end
         OP_OR_IMM_WITH_ACC: begin
            m_acc = exp_alu(o, m_acc, r, i);
            m_z = (m_acc == 8'h00);
         end
         OP_READ_SPECIAL_PAGE_REG: if (f >= SFR_RD_MIN) m_acc = s;
         OP_LONG_SUBROUTINE_CALL: begin
            two = 1'b1;
            m_sp = m_sp + 3'h1;
         end
         default: ;
      endcase
      @(posedge clk);
      // a refused take must not touch the accumulator
      op <= OP_OR_IMM_WITH_ACC; imm <= 8'hFF; vld <= two & rf;
      #1;
      // payloads are gated on the expected strobe so a stuck or unknown strobe still trips
      ew = d && (o == OP_INC_SKIP_IF_ZERO || o == OP_OR_ACC_WITH_REG);
      `CHK("acc", m_acc, acc)
      `CHK("zero", m_z, zero)
      `CHK("reg_we", ew, rwe)
      if (ew) `CHK("reg_wdata", res, wd)
      if (ew) `CHK("reg_waddr", a, rwa)
      `CHK("sfr_we", o == OP_WRITE_SPECIAL_PAGE_REG, swe)
      if (o == OP_WRITE_SPECIAL_PAGE_REG) `CHK("sfr_wdata", old, sd)
      if (o == OP_WRITE_SPECIAL_PAGE_REG) `CHK("sfr_waddr", f, swa)
      `CHK("flush", two && o == OP_INC_SKIP_IF_ZERO, flush)
      `CHK("busy", two, busy)
      `CHK("push", o == OP_LONG_SUBROUTINE_CALL, push)
      if (o == OP_LONG_SUBROUTINE_CALL) `CHK("push_data", p + ONE_PC, pd)
      if (o == OP_LONG_SUBROUTINE_CALL) `CHK("push_level", osp, pl)
      `CHK("sp", m_sp, sp)
      if (two) begin
         @(posedge clk);
         vld <= 1'b0;
         #1;
         `CHK("pc_load", o == OP_LONG_SUBROUTINE_CALL, pld)
         if (o == OP_LONG_SUBROUTINE_CALL) `CHK("pc_target", t, pt)
         `CHK("busy_end", 1'b0, busy)
         `CHK("acc_hold", m_acc, acc)
         `CHK("zero_hold", m_z, zero)
         `CHK("push_end", 1'b0, push)
      end
   endtask

   // ==========================================
   // main sequence
   initial begin
      logic [31:0] v;
      logic [31:0] w;
      rst_b = 1'b0; vld = 1'b0; op = OP_NOP; dst = 1'b0; ra = 6'h00; imm = 8'h00;
      rrd = 8'h00; srd = 8'h00; sa = 4'h0; tgt = 10'h000; pc = 10'h000;
      m_acc = ACC_RST; m_z = ZERO_RST; m_sp = 3'h0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      `CHK("acc_rst", ACC_RST, acc)
      `CHK("sp_rst", 3'h0, sp)
      // corner cases: skip into register and acc, bounds of page index and target
      run(OP_INC_SKIP_IF_ZERO, 1'b1, 6'h3F, 8'h00, 8'hFF, 8'h00, 4'h0, 10'h000, 10'h000, 1'b1);
      run(OP_INC_SKIP_IF_ZERO, 1'b0, 6'h00, 8'h00, 8'hFF, 8'h00, 4'h0, 10'h000, 10'h000, 1'b0);
      run(OP_OR_ACC_WITH_REG, 1'b1, 6'h2A, 8'h00, 8'h00, 8'h00, 4'h0, 10'h000, 10'h000, 1'b0);
      run(OP_READ_SPECIAL_PAGE_REG, 1'b0, 6'h00, 8'h00, 8'h00, 8'h55, 4'h4, 10'h0, 10'h0, 1'b0);
      run(OP_READ_SPECIAL_PAGE_REG, 1'b0, 6'h00, 8'h00, 8'h00, 8'h5A, 4'h5, 10'h0, 10'h0, 1'b0);
      run(OP_WRITE_SPECIAL_PAGE_REG, 1'b0, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 10'h0, 10'h0, 1'b0);
      run(OP_LONG_SUBROUTINE_CALL, 1'b0, 6'h00, 8'h00, 8'h00, 8'h00, 4'h0, 10'h3FF, 10'h3FF, 1'b1);
      // random traffic; one in two increments sees an all-ones register
      for (int k = 0; k < 400; k++) begin
         v = xs();
         w = xs();
         run(mies_op_e'(3'(v % 7)), v[3], v[9:4], w[7:0], v[10] ? 8'hFF : w[15:8], w[23:16],
             v[14:11], w[31:22], v[25:16], v[26]);
      end
      close_out();
   end

   // watchdog, well beyond the roughly 900 cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule
